// *** lpwr_pkg.sv ***
package lpwr_pkg;
	// apb register map (byte addresses)
	localparam logic [7:0] LPWR_CTRL_ADDR    = 8'h00;
	localparam logic [7:0] LPWR_STATUS_ADDR  = 8'h04;
	localparam logic [7:0] LPWR_DELAY_ADDR   = 8'h08;
	// control register fields
	localparam int CTRL_CONV_POWER_BIT  = 0;
	localparam int CTRL_SERIAL_ON_BIT   = 1;
	localparam int CTRL_TX_ON_BIT       = 2;
	localparam int CTRL_RX_ON_BIT       = 3;
	localparam int CTRL_WDOG_OFF_BIT    = 4;
	localparam int CTRL_WAKE_DELAY_BIT  = 5;
	localparam int CTRL_WIDTH           = 6;
	localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 6'h20;
	// default stabilisation length in oscillator cycles
	localparam int OSC_DELAY_CYCLES     = 4064;
	localparam int DELAY_WIDTH          = 16;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_WAIT,
		ST_STOP,
		ST_STAB,
		ST_POR
	} lpwr_state_t;

	// peripheral clock and power enables
	typedef struct packed {
		logic conv_power;
		logic serial_periph_on;
		logic tx_on;
		logic rx_on;
		logic timer_run;
	} lpwr_periph_t;

	// wake request to cpu
	typedef struct packed {
		logic resume;
		logic service_nmi;
		logic skip_nmi;
	} lpwr_wake_t;
endpackage

// *** lpwr_ctrl.sv ***
// Behaviour
// - sleep_opcode stacks registers, halts cpu until a qualified interrupt arrives
// - wait ends on maskable pin, ext_nmi_pin while nmi mask is 0, or any peripheral interrupt
// - oscillator keeps running throughout wait
// - wait repeats bus reads at the stacked flags_word address
// - timer stops in wait only if mask bit and watchdog_off both 1
// - converter current removed when converter_power written 0; wait leaves it
// - serial_periph_on, tx_on, rx_on gate their units, also during wait
// - stop entered only when halt-permit bit is 0, else a no-op
// - stop halts every clock including the oscillator
// - cpu state and pins held in stop; interrupt wake resumes seamlessly
// - reset leaving stop runs a normal reset sequence
// - maskable pin wakes stop only when its mask bit is clear
// - nmi wake with nmi mask 0 starts stacking and normal service
// - nmi wake with nmi mask 1 continues after stop, nothing pending
// - stabilisation delay after stop, skipped when osc_wake_delay is 0
// - reset sets osc_wake_delay to one; software may clear it
// - power-on reset always delays; warm reset while clocks run does not
// - nmi service sets both nmi and maskable mask bits after stacking
`timescale 1ns/1ps
module lpwr_ctrl
	import lpwr_pkg::*;
#(
	parameter int unsigned STAB_CYCLES = OSC_DELAY_CYCLES,
	parameter int unsigned ADDR_W      = 16
) (
	// clock and reset
	input  wire logic                 core_clk_i,
	input  wire logic                 sys_rst_i,
	input  wire logic                 clk_en_i,
	input  wire logic                 por_i,
	// apb slave
	input  wire logic                 psel_i,
	input  wire logic                 penable_i,
	input  wire logic                 pwrite_i,
	input  wire logic [7:0]           paddr_i,
	input  wire logic [31:0]          pwdata_i,
	output logic      [31:0]          prdata_o,
	output logic                      pready_o,
	output logic                      pslverr_o,
	// cpu core
	input  wire logic                 sleep_opcode_i,
	input  wire logic                 stop_opcode_i,
	input  wire logic                 stack_done_i,
	input  wire logic [ADDR_W-1:0]    flags_addr_i,
	input  wire logic                 halt_permit_i,
	input  wire logic                 irq_mask_i,
	input  wire logic                 nmi_mask_i,
	input  wire logic                 periph_irq_i,
	input  wire logic                 nmi_serviced_i,
	output logic                      cpu_halt_o,
	output logic                      stack_req_o,
	output logic                      set_masks_o,
	output lpwr_wake_t                wake_o,
	output logic                      bus_rd_o,
	output logic      [ADDR_W-1:0]    bus_addr_o,
	// pins (both interrupt pins active-low levels, irq_edge_pend_i active-high)
	input  wire logic                 irq_pin_n_i,
	input  wire logic                 ext_nmi_pin_n_i,
	input  wire logic                 irq_edge_pend_i,
	// clocks, warm reset and peripheral enables
	output logic                      osc_run_o,
	output logic                      clk_gate_o,
	output logic                      warm_reset_o,
	output lpwr_periph_t              periph_o
);
	// the delay counter and the address path have fixed widths
	initial begin
		if (STAB_CYCLES < 1 || STAB_CYCLES >= (1 << DELAY_WIDTH))
			$error("STAB_CYCLES out of range");
		if (ADDR_W < 1 || ADDR_W > 32)
			$error("ADDR_W out of range");
	end

	localparam logic [DELAY_WIDTH-1:0] STAB_LAST = DELAY_WIDTH'(STAB_CYCLES - 1);
	localparam int                     N_PINS    = 3;
	// idle levels: both interrupt pins high, edge latch clear, so reset shows no wake
	localparam logic [N_PINS-1:0]      PIN_IDLE  = 3'h3;

	// pin synchronisers: stage one only feeds stage two
	wire [N_PINS-1:0] pin_raw;
	wire [N_PINS-1:0] pin_sync;
	assign pin_raw = {irq_edge_pend_i, ext_nmi_pin_n_i, irq_pin_n_i};
	for (genvar g = 0; g < N_PINS; g++) begin : g_sync
		// one pair of flops per pin
		logic s1_q;
		logic s2_q;
		always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				s1_q <= PIN_IDLE[g];
				s2_q <= PIN_IDLE[g];
			end else if (clk_en_i) begin
				s1_q <= pin_raw[g];
				s2_q <= s1_q;
			end
		end
		assign pin_sync[g] = s2_q;
	end

	wire irq_low  = ~pin_sync[0];
	wire nmi_low  = ~pin_sync[1];
	wire edge_pnd = pin_sync[2];

	// state and control registers
	logic [CTRL_WIDTH-1:0]  ctrl_q;
	logic [DELAY_WIDTH-1:0] delay_cnt_q;
	logic [DELAY_WIDTH-1:0] delay_cnt_d;
	lpwr_state_t            state_q;
	lpwr_state_t            state_d;
	logic                   por_seen_q;
	logic                   nmi_kind_q;
	logic                   nmi_kind_d;

	// apb decode; the slave always answers one cycle after setup
	wire apb_access = psel_i & penable_i;
	wire setup_ph   = psel_i & ~penable_i;
	wire wr_ctrl    = apb_access & pwrite_i & (paddr_i == LPWR_CTRL_ADDR);
	wire rd_hit     = (paddr_i == LPWR_CTRL_ADDR) | (paddr_i == LPWR_STATUS_ADDR)
	                | (paddr_i == LPWR_DELAY_ADDR);
	wire [31:0] rd_mux =
		(paddr_i == LPWR_CTRL_ADDR)   ? {26'h0, ctrl_q} :
		(paddr_i == LPWR_STATUS_ADDR) ? {29'h0, state_q} :
		(paddr_i == LPWR_DELAY_ADDR)  ? {16'h0, delay_cnt_q} : 32'h0;
	wire [31:0] prdata_d  = (setup_ph & ~pwrite_i) ? rd_mux : 32'h0;
	wire        pslverr_d = setup_ph & ~rd_hit;

	// reset leaves osc_wake_delay at one
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_q <= CTRL_RESET;
		end else if (clk_en_i && wr_ctrl) begin
			ctrl_q <= pwdata_i[CTRL_WIDTH-1:0];
		end
	end

	// apb answer registers: pready, pslverr and prdata stand for one cycle
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pready_o <= 1'b0;
		end else if (clk_en_i) begin
			pready_o <= setup_ph;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pslverr_o <= 1'b0;
		end else if (clk_en_i) begin
			pslverr_o <= pslverr_d;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prdata_o <= 32'h0;
		end else if (clk_en_i) begin
			prdata_o <= prdata_d;
		end
	end

	// wake qualification
	wire wait_wake = irq_low & ~irq_mask_i | nmi_low & ~nmi_mask_i | periph_irq_i;
	wire irq_wake  = (irq_low | edge_pnd) & ~irq_mask_i;
	// the non-maskable pin wakes stop whatever its mask; the mask only picks the path
	wire stop_wake = irq_wake | nmi_low;
	wire stop_ok   = stop_opcode_i & ~halt_permit_i;
	// counter runs 0 to STAB_LAST, so the delay lasts STAB_CYCLES cycles
	wire stab_done = delay_cnt_q == STAB_LAST;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_POR:  if (stab_done) state_d = ST_RUN;
			ST_RUN: begin
				if (sleep_opcode_i)
					state_d = ST_WAIT;
				else if (stop_ok)
					state_d = ST_STOP;
			end
			ST_WAIT: if (wait_wake) state_d = ST_RUN;
			ST_STOP: begin
				if (stop_wake)
					state_d = ctrl_q[CTRL_WAKE_DELAY_BIT] ? ST_STAB : ST_RUN;
			end
			ST_STAB: if (stab_done) state_d = ST_RUN;
			default: state_d = ST_RUN;
		endcase
	end

	// por strap caught after release; warm resets skip the delay
	wire por_entry = ~por_seen_q & por_i;
	wire in_delay  = (state_q == ST_STAB) | (state_q == ST_POR);
	assign delay_cnt_d = (in_delay && !stab_done) ? delay_cnt_q + 1'b1 : '0;
	// wake source kept across the delay so the nmi path is still chosen right
	assign nmi_kind_d  = (state_q == ST_STOP && stop_wake) ? nmi_low & ~irq_wake : nmi_kind_q;

	// state registers
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_q <= ST_RUN;
		end else if (clk_en_i) begin
			state_q <= por_entry ? ST_POR : state_d;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			por_seen_q <= 1'b0;
		end else if (clk_en_i) begin
			por_seen_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			delay_cnt_q <= '0;
		end else if (clk_en_i) begin
			delay_cnt_q <= delay_cnt_d;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			nmi_kind_q <= 1'b0;
		end else if (clk_en_i) begin
			nmi_kind_q <= nmi_kind_d;
		end
	end

	// output next values; cpu frozen in wait, stop and delay, state held
	wire leave_stop = (state_q == ST_STAB && stab_done)
	                | (state_q == ST_STOP && stop_wake && !ctrl_q[CTRL_WAKE_DELAY_BIT]);
	wire nmi_from_stop = leave_stop & (nmi_kind_q | (state_q == ST_STOP & nmi_low & ~irq_wake));
	// the watchdog needs the timer, so in wait it only stops once the watchdog is off
	wire timer_hold = state_d == ST_WAIT && irq_mask_i && ctrl_q[CTRL_WDOG_OFF_BIT];
	wire cpu_halt_d   = state_d != ST_RUN;
	wire stack_req_d  = (state_q == ST_RUN & sleep_opcode_i)
	                  | (nmi_from_stop & ~nmi_mask_i);
	wire set_masks_d  = nmi_serviced_i & stack_done_i;
	wire bus_rd_d     = state_d == ST_WAIT;
	wire osc_run_d    = state_d != ST_STOP;
	wire clk_gate_d   = state_d != ST_STOP & state_d != ST_STAB;
	// bus reset sequence runs while sys_rst_i is held and through the por delay (state ST_POR)
	wire warm_reset_d = state_q == ST_POR;
	lpwr_wake_t   wake_d;
	lpwr_periph_t periph_d;
	assign wake_d.resume      = (state_q == ST_WAIT & wait_wake) | leave_stop;
	assign wake_d.service_nmi = nmi_from_stop & ~nmi_mask_i;
	assign wake_d.skip_nmi    = nmi_from_stop & nmi_mask_i;
	assign periph_d.conv_power       = ctrl_q[CTRL_CONV_POWER_BIT];
	assign periph_d.serial_periph_on = ctrl_q[CTRL_SERIAL_ON_BIT];
	assign periph_d.tx_on            = ctrl_q[CTRL_TX_ON_BIT];
	assign periph_d.rx_on            = ctrl_q[CTRL_RX_ON_BIT];
	assign periph_d.timer_run        = !timer_hold && state_d != ST_STOP;

	// outputs, all registered: nothing combinational leaves the block
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cpu_halt_o <= 1'b0;
		end else if (clk_en_i) begin
			cpu_halt_o <= cpu_halt_d;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			stack_req_o <= 1'b0;
		end else if (clk_en_i) begin
			stack_req_o <= stack_req_d;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			set_masks_o <= 1'b0;
		end else if (clk_en_i) begin
			set_masks_o <= set_masks_d;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wake_o <= '0;
		end else if (clk_en_i) begin
			wake_o <= wake_d;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bus_rd_o <= 1'b0;
		end else if (clk_en_i) begin
			bus_rd_o <= bus_rd_d;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bus_addr_o <= '0;
		end else if (clk_en_i) begin
			bus_addr_o <= flags_addr_i;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			osc_run_o <= 1'b1;
		end else if (clk_en_i) begin
			osc_run_o <= osc_run_d;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			clk_gate_o <= 1'b1;
		end else if (clk_en_i) begin
			clk_gate_o <= clk_gate_d;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			warm_reset_o <= 1'b1;
		end else if (clk_en_i) begin
			warm_reset_o <= warm_reset_d;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			periph_o <= '0;
		end else if (clk_en_i) begin
			periph_o <= periph_d;
		end
	end
endmodule

// *** lpwr_ctrl_monitor.sv ***
`timescale 1ns/1ps
module lpwr_ctrl_monitor
	import lpwr_pkg::*;
#(
	parameter int unsigned ADDR_W = 16
) (
	input wire logic              core_clk_i, sys_rst_i, sleep_opcode_i, stop_opcode_i,
	input wire logic              halt_permit_i, irq_mask_i, periph_irq_i, ext_nmi_pin_n_i,
	input wire logic              irq_edge_pend_i, cpu_halt_o, stack_req_o, bus_rd_o,
	input wire logic              osc_run_o, clk_gate_o,
	input wire logic [ADDR_W-1:0] bus_addr_o, flags_addr_i,
	input wire lpwr_wake_t        wake_o,
	input wire lpwr_periph_t      periph_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	property p_wait_in;
		sleep_opcode_i && !cpu_halt_o |=> cpu_halt_o && stack_req_o && bus_rd_o;
	endproperty
	a_wait_in: assert property (p_wait_in) else $error("wait entry");
	property p_rd_addr;
		bus_rd_o && $past(bus_rd_o) |-> bus_addr_o == $past(flags_addr_i);
	endproperty
	a_rd_addr: assert property (p_rd_addr) else $error("wait read address");
	property p_osc_wait;
		bus_rd_o |-> osc_run_o && clk_gate_o;
	endproperty
	a_osc_wait: assert property (p_osc_wait) else $error("oscillator off in wait");
	property p_wait_wake;
		bus_rd_o && periph_irq_i && !irq_mask_i |-> ##[1:3] wake_o.resume;
	endproperty
	a_wait_wake: assert property (p_wait_wake) else $error("no wake");
	property p_stop_nop;
		stop_opcode_i && halt_permit_i && !cpu_halt_o |=> !cpu_halt_o && osc_run_o;
	endproperty
	a_stop_nop: assert property (p_stop_nop) else $error("stop not ignored");
	property p_stop_in;
		stop_opcode_i && !halt_permit_i && !cpu_halt_o |=> !osc_run_o && !clk_gate_o;
	endproperty
	a_stop_in: assert property (p_stop_in) else $error("clocks not halted");
	// the pins pass two sync flops, so four quiet cycles cover any wake in flight
	property p_irq_masked;
		(!osc_run_o && irq_mask_i && ext_nmi_pin_n_i && !irq_edge_pend_i)[*4] |=> !osc_run_o;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("masked wake");
	property p_stop_hold;
		!osc_run_o && !$past(osc_run_o) |-> $stable(periph_o);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("state moved in stop");
endmodule

bind lpwr_ctrl lpwr_ctrl_monitor #(.ADDR_W(ADDR_W)) i_lpwr_ctrl_monitor (.*);

// *** lpwr_cpu_model.sv ***
`timescale 1ns/1ps
module lpwr_cpu_model #(
	parameter logic [15:0] FLAGS_ADDR = 16'h01f7
) (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        sys_rst_i,
	// requests from the controller
	input  wire logic        stack_req_i,
	input  wire logic        service_nmi_i,
	// answers
	output logic             stack_done_o,
	output logic             nmi_serviced_o,
	output logic [15:0]      flags_addr_o
);
	assign flags_addr_o = FLAGS_ADDR;
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			stack_done_o   <= 1'h0;
			nmi_serviced_o <= 1'h0;
		end else begin
			stack_done_o   <= stack_req_i | service_nmi_i;
			nmi_serviced_o <= service_nmi_i;
		end
	end
endmodule

// *** lpwr_ctrl_tb.sv ***
`timescale 1ns/1ps
module lpwr_ctrl_tb;
	import lpwr_pkg::*;
	localparam int STAB = 8;
	logic core_clk_i = 0, sys_rst_i = 1, clk_en_i = 1, por_i = 1, psel_i = 0, penable_i = 0;
	logic pwrite_i = 0, sleep_opcode_i = 0, stop_opcode_i = 0, halt_permit_i = 0, irq_mask_i = 1;
	logic nmi_mask_i = 0, periph_irq_i = 0, irq_pin_n_i = 1, ext_nmi_pin_n_i = 1;
	logic irq_edge_pend_i = 0, seen_masks = 0, pready_o, pslverr_o, cpu_halt_o, stack_req_o;
	logic set_masks_o, bus_rd_o, osc_run_o, clk_gate_o, warm_reset_o, stack_done_i, err;
	logic nmi_serviced_i;
	logic [7:0] paddr_i = 0;
	logic [31:0] pwdata_i = 0, prdata_o, rd;
	logic [15:0] bus_addr_o, flags_addr_i;
	lpwr_wake_t wake_o, w;
	lpwr_periph_t periph_o;
	int n_errors = 0, checked = 0, n, n0;
	always #10 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) if (set_masks_o === 1'h1) seen_masks <= 1'h1;
	lpwr_ctrl #(.STAB_CYCLES(STAB)) i_lpwr_ctrl (.*);
	lpwr_cpu_model i_lpwr_cpu_model (.core_clk_i, .sys_rst_i, .stack_req_i(stack_req_o),
		.service_nmi_i(wake_o.service_nmi), .stack_done_o(stack_done_i),
		.nmi_serviced_o(nmi_serviced_i), .flags_addr_o(flags_addr_i));
	task chk(input string nm, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask
	task tk(input int k);
		repeat (k) @(posedge core_clk_i);
		#1;
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		psel_i    <= 1;
		pwrite_i  <= wr;
		paddr_i   <= a;
		pwdata_i  <= d;
		@(posedge core_clk_i);
		penable_i <= 1;
		@(posedge core_clk_i);
		while (pready_o !== 1'h1) @(posedge core_clk_i);
		rd = prdata_o;
		err = pslverr_o;
		psel_i    <= 0;
		penable_i <= 0;
	endtask
	task pls(input bit is_stop);
		@(posedge core_clk_i);
		if (is_stop)
			stop_opcode_i <= 1;
		else
			sleep_opcode_i <= 1;
		@(posedge core_clk_i);
		stop_opcode_i <= 0;
		sleep_opcode_i <= 0;
	endtask
	// pulses stand one cycle, so every edge is looked at until one shows
	task wk();
		n = 0;
		w = '0;
		while (w === '0 && n < 100) begin
			tk(1);
			w = wake_o;
			n++;
		end
	endtask
	task stp();
		pls(1);
		tk(1);
		chk("osc_stop", 0, osc_run_o | clk_gate_o);
		irq_pin_n_i <= 0;
		tk(6);
		chk("irq_masked", 0, osc_run_o);
		irq_pin_n_i <= 1;
		ext_nmi_pin_n_i <= 0;
		wk();
		ext_nmi_pin_n_i <= 1;
	endtask
	task rst();
		@(posedge core_clk_i);
		sys_rst_i <= 1;
		tk(2);
		sys_rst_i <= 0;
		tk(3);
	endtask
	task end_sim();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge core_clk_i);
		n_errors++;
		end_sim();
	end
	initial begin
		repeat (6) @(posedge core_clk_i);
		sys_rst_i <= 0;
		tk(1);
		por_i <= 0;
		tk(1);
		chk("por_warm", 1, warm_reset_o);
		n = 0;
		while (cpu_halt_o === 1'h1 && n < 50) begin
			tk(1);
			n++;
		end
		chk("por_delay", 1, n >= STAB - 2);
		apb(0, LPWR_CTRL_ADDR, 0);
		chk("ctrl_reset", 32'h20, rd);
		apb(0, 8'h0c, 0);
		chk("unmapped", 1, err);
		apb(1, LPWR_CTRL_ADDR, 32'h1f);
		tk(2);
		chk("periph_run", 5'h1f, periph_o);
		$display("test reset and registers done");
		pls(0);
		#1;
		chk("wait_halt", 1, cpu_halt_o & stack_req_o);
		tk(2);
		chk("bus_addr", flags_addr_i, bus_addr_o);
		chk("periph_wait", 5'h1e, periph_o);
		chk("osc_wait", 1, osc_run_o);
		ext_nmi_pin_n_i <= 0;
		wk();
		chk("nmi_wake", 1, w.resume);
		ext_nmi_pin_n_i <= 1;
		irq_mask_i <= 0;
		tk(4);
		pls(0);
		tk(2);
		chk("timer_wait", 1, periph_o.timer_run);
		periph_irq_i <= 1;
		wk();
		chk("periph_wake", 1, w.resume);
		periph_irq_i <= 0;
		irq_mask_i <= 1;
		$display("test wait done");
		halt_permit_i <= 1;
		tk(2);
		pls(1);
		tk(2);
		chk("stop_nop", 1, osc_run_o & ~cpu_halt_o);
		halt_permit_i <= 0;
		tk(2);
		stp();
		n0 = n;
		chk("nmi_service", 1, w.service_nmi);
		tk(4);
		chk("masks_set", 1, seen_masks);
		apb(1, LPWR_CTRL_ADDR, 32'h3f);
		nmi_mask_i <= 1;
		tk(2);
		stp();
		chk("nmi_skip", 1, w.skip_nmi & ~w.service_nmi);
		chk("stab", 1, n >= n0 + STAB);
		irq_mask_i <= 0;
		pls(1);
		irq_pin_n_i <= 0;
		wk();
		chk("irq_wake", 1, w.resume & ~w.skip_nmi);
		irq_pin_n_i <= 1;
		irq_mask_i <= 1;
		$display("test stop done");
		pls(1);
		rst();
		chk("reset_periph", 4'h0, periph_o[4:1]);
		tk(STAB + 4);
		apb(0, LPWR_CTRL_ADDR, 0);
		chk("ctrl_rearm", 32'h20, rd);
		rst();
		chk("warm_reset", 0, cpu_halt_o);
		chk("warm_flag", 0, warm_reset_o);
		$display("test reset recovery done");
		end_sim();
	end
endmodule
